//--- logic/pbc_pkg.sv
// Package for the buck one configuration register slice
package pbc_pkg;
   // Register offsets
   localparam logic [7:0] OFS_SCRATCH_D = 8'h1F;
   localparam logic [7:0] OFS_RUN_VOLT = 8'h20;
   localparam logic [7:0] OFS_STBY_VOLT = 8'h21;
   localparam logic [7:0] OFS_SLEEP_VOLT = 8'h22;
   localparam logic [7:0] OFS_SW_MODE = 8'h23;
   // Field positions and widths
   localparam int VOLT_W = 5;
   localparam int MODE_W = 4;
   localparam int OFF_SEL_BIT = 5;
   // Reset values
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam logic [7:0] RESERVED_READ = 8'h00;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   // Regulator operating state, one-hot
   typedef enum logic [3:0] {
      PBC_RUN = 4'b0001,
      PBC_STBY = 4'b0010,
      PBC_SLEEP = 4'b0100,
      PBC_OFF = 4'b1000
   } pbc_reg_state_t;

   // Configuration loaded from one-time-programmable memory
   typedef struct packed {
      logic [4:0] run_volt;
      logic [4:0] stby_volt;
      logic [4:0] sleep_volt;
      logic [3:0] sw_mode;
   } pbc_otp_t;

   // Software register port
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pbc_bus_t;

   // Main-domain state
   typedef struct packed {
      logic [4:0] run_volt;
      logic [4:0] stby_volt;
      logic [4:0] sleep_volt;
      logic [3:0] sw_mode;
      logic off_sel;
      logic [7:0] rdata;
      pbc_reg_state_t state;
      logic [4:0] volt_out;
   } pbc_main_t;
endpackage

//--- logic/pbc_retained.sv
// Retained scratch byte held in the coin-cell domain
`timescale 1ns/10ps
module pbc_retained
(
   // Clock and coin-cell reset
   input wire logic clk,
   input wire logic coin_cell_por_n,
   // Write port
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   // Stored value
   output logic [7:0] value
);
   logic [7:0] next_value;

   // Only a software write changes the byte
   always_comb
   begin
      next_value = value;
      if (wr_en)
      begin
         next_value = wdata;
      end
   end

   always_ff @(posedge clk or negedge coin_cell_por_n)
   begin
      if (!coin_cell_por_n)
      begin
         value <= pbc_pkg::SCRATCH_RESET;
      end
      else
      begin
         value <= next_value;
      end
   end
endmodule

//--- logic/pbc_regs.sv
// Buck one configuration registers and retained scratch byte
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module pbc_regs
(
   // Clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic coin_cell_por_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // OTP defaults
   input wire pbc_pkg::pbc_otp_t otp,
   // Power events
   input wire logic standby_req,
   input wire logic turn_off,
   input wire logic turn_on,
   // Regulator controls
   output logic [4:0] buck_one_volt,
   output logic [3:0] buck_one_switch_mode,
   output logic buck_one_off_mode_select,
   output logic buck_one_enable,
   output logic buck_one_sleep
);
   logic [1:0] rst_sync;
   logic rst_n_int;
   pbc_pkg::pbc_bus_t bus;
   pbc_pkg::pbc_main_t st;
   pbc_pkg::pbc_main_t next_st;
   logic [7:0] scratch;
   logic scratch_wr;
   logic enable_q;
   logic sleep_q;
   logic next_enable;
   logic next_sleep;
   // Register view after the OTP overlay, before this cycle's write
   pbc_pkg::pbc_main_t base;
   // Low only in the first cycle out of reset
   logic loaded;

   // Address match, used by both the write and read decoders
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_sync <= pbc_pkg::SYNC_RESET;
      end
      else
      begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync[1];

   // Bundle the bus
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   assign scratch_wr = bus.wr && hit(bus.addr, pbc_pkg::OFS_SCRATCH_D);

   // coin-cell domain
   // Scratch lives on the coin cell, so main reset never touches it
   pbc_retained u_retained
   (
      .clk(clk),
      .coin_cell_por_n(coin_cell_por_n),
      .wr_en(scratch_wr),
      .wdata(bus.wdata),
      .value(scratch)
   );

   // Register writes, reads and regulator state
   always_comb
   begin
      // OTP defaults on first cycle
      // The async reset branch may only load constants, so the OTP copy
      // is taken here on the first clocked cycle instead
      base = st;
      if (!loaded)
      begin
         base.run_volt = otp.run_volt;
         base.stby_volt = otp.stby_volt;
         base.sleep_volt = otp.sleep_volt;
         base.sw_mode = otp.sw_mode;
      end
      // A write in the load cycle still wins over the OTP copy
      next_st = base;
      if (bus.wr)
      begin
         if (hit(bus.addr, pbc_pkg::OFS_RUN_VOLT))
         begin
            next_st.run_volt = bus.wdata[pbc_pkg::VOLT_W-1:0];
         end
         else if (hit(bus.addr, pbc_pkg::OFS_STBY_VOLT))
         begin
            next_st.stby_volt = bus.wdata[pbc_pkg::VOLT_W-1:0];
         end
         else if (hit(bus.addr, pbc_pkg::OFS_SLEEP_VOLT))
         begin
            next_st.sleep_volt = bus.wdata[pbc_pkg::VOLT_W-1:0];
         end
         else if (hit(bus.addr, pbc_pkg::OFS_SW_MODE))
         begin
            next_st.sw_mode = bus.wdata[pbc_pkg::MODE_W-1:0];
            next_st.off_sel = bus.wdata[pbc_pkg::OFF_SEL_BIT];
         end
      end

      // Read data stands only in the cycle after the strobe
      next_st.rdata = pbc_pkg::RESERVED_READ;
      if (bus.rd)
      begin
         if (hit(bus.addr, pbc_pkg::OFS_SCRATCH_D))
         begin
            next_st.rdata = scratch;
         end
         else if (hit(bus.addr, pbc_pkg::OFS_RUN_VOLT))
         begin
            next_st.rdata = {3'h0, base.run_volt};
         end
         else if (hit(bus.addr, pbc_pkg::OFS_STBY_VOLT))
         begin
            next_st.rdata = {3'h0, base.stby_volt};
         end
         else if (hit(bus.addr, pbc_pkg::OFS_SLEEP_VOLT))
         begin
            next_st.rdata = {3'h0, base.sleep_volt};
         end
         else if (hit(bus.addr, pbc_pkg::OFS_SW_MODE))
         begin
            next_st.rdata = {2'h0, base.off_sel, 1'b0, base.sw_mode};
         end
      end

      // Turn-off has priority over standby; turn-on wakes from off/sleep
      case (st.state)
         pbc_pkg::PBC_RUN:
         begin
            if (turn_off)
            begin
               next_st.state = st.off_sel ? pbc_pkg::PBC_SLEEP
                                          : pbc_pkg::PBC_OFF;
            end
            else if (standby_req)
            begin
               next_st.state = pbc_pkg::PBC_STBY;
            end
         end
         pbc_pkg::PBC_STBY:
         begin
            if (turn_off)
            begin
               next_st.state = st.off_sel ? pbc_pkg::PBC_SLEEP
                                          : pbc_pkg::PBC_OFF;
            end
            else if (!standby_req)
            begin
               next_st.state = pbc_pkg::PBC_RUN;
            end
         end
         pbc_pkg::PBC_SLEEP,
         pbc_pkg::PBC_OFF:
         begin
            if (turn_on)
            begin
               next_st.state = pbc_pkg::PBC_RUN;
            end
         end
         default:
         begin
            next_st.state = pbc_pkg::PBC_RUN;
         end
      endcase

      // Voltage code follows the state being entered
      case (next_st.state)
         pbc_pkg::PBC_STBY:
         begin
            next_st.volt_out = next_st.stby_volt;
         end
         pbc_pkg::PBC_SLEEP:
         begin
            next_st.volt_out = next_st.sleep_volt;
         end
         default:
         begin
            next_st.volt_out = next_st.run_volt;
         end
      endcase
      next_enable = (next_st.state != pbc_pkg::PBC_OFF);
      next_sleep = (next_st.state == pbc_pkg::PBC_SLEEP);
   end

   // State register; outputs stay zero until the OTP copy is taken
   always_ff @(posedge clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         st <= '0;
         enable_q <= 1'b0;
         sleep_q <= 1'b0;
      end
      else
      begin
         st <= next_st;
         enable_q <= next_enable;
         sleep_q <= next_sleep;
      end
   end

   always_ff @(posedge clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         loaded <= 1'b0;
      end
      else
      begin
         loaded <= 1'b1;
      end
   end

   // Outputs straight from flops
   assign rdata = st.rdata;
   assign buck_one_volt = st.volt_out;
   assign buck_one_switch_mode = st.sw_mode;
   assign buck_one_off_mode_select = st.off_sel;
   assign buck_one_enable = enable_q;
   assign buck_one_sleep = sleep_q;
endmodule

//--- test/pbc_regs_chk.sv
// Port assertions for the buck one register slice
`timescale 1ns/10ps
module pbc_regs_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // Events and controls
   input wire logic turn_off,
   input wire logic [3:0] buck_one_switch_mode,
   input wire logic buck_one_off_mode_select,
   input wire logic buck_one_enable,
   input wire logic buck_one_sleep
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_idle;
      !rd |=> rdata == 8'h00;
   endproperty
   property p_volt;
      rd && addr inside {8'h20, 8'h21, 8'h22} |=> rdata[7:5] == 3'h0;
   endproperty
   property p_mres;
      rd && addr == pbc_pkg::OFS_SW_MODE |=> rdata[7:6] == 2'h0 && !rdata[4];
   endproperty
   property p_mirror;
      rd && addr == pbc_pkg::OFS_SW_MODE |=> rdata[3:0] == buck_one_switch_mode
         && rdata[5] == buck_one_off_mode_select;
   endproperty
   property p_unmap;
      rd && (addr < 8'h1F || addr > 8'h23) |=> rdata == 8'h00;
   endproperty
   property p_off;
      $rose(turn_off) && !buck_one_off_mode_select |-> ##[1:4] !buck_one_enable;
   endproperty
   property p_sleep;
      $rose(turn_off) && buck_one_off_mode_select |-> ##[1:4] buck_one_sleep;
   endproperty
   property p_excl;
      !buck_one_enable |-> !buck_one_sleep;
   endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   a_volt: assert property (p_volt) else $error("volt upper bits");
   a_mres: assert property (p_mres) else $error("mode reserved");
   a_mirror: assert property (p_mirror) else $error("mode mismatch");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_off: assert property (p_off) else $error("no full off");
   a_sleep: assert property (p_sleep) else $error("no sleep");
   a_excl: assert property (p_excl) else $error("off and sleep");
   // Main scenarios reached
   c_rd: cover property (rd && addr == pbc_pkg::OFS_SCRATCH_D);
   c_off: cover property ($rose(turn_off) && !buck_one_off_mode_select);
   c_slp: cover property ($rose(turn_off) && buck_one_off_mode_select);
endmodule
bind pbc_regs pbc_regs_chk u_chk (.clk(clk), .reset_n(reset_n),
   .addr(addr), .rd(rd), .rdata(rdata), .turn_off(turn_off),
   .buck_one_switch_mode(buck_one_switch_mode),
   .buck_one_off_mode_select(buck_one_off_mode_select),
   .buck_one_enable(buck_one_enable), .buck_one_sleep(buck_one_sleep));

//--- test/pbc_regs_tb_top.sv
// Self-checking bench for the buck one register slice
`timescale 1ns/10ps
module pbc_regs_tb_top;
   logic clk = 1'b0, reset_n = 1'b0, coin_cell_por_n = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic wr = 1'b0, rd = 1'b0, standby_req = 1'b0;
   logic turn_off = 1'b0, turn_on = 1'b0;
   logic [4:0] volt;
   logic [3:0] mode;
   logic off_sel, enable, sleep;
   int miscompares = 0, n_checks = 0;
   logic [7:0] m [7] = '{8'h00, 8'hFF, 8'h1F, 8'h1F, 8'h1F, 8'h2F, 8'h00};
   pbc_pkg::pbc_otp_t otp = '{5'h0D, 5'h06, 5'h03, 4'h9};
   // 50 ns clock
   initial
   begin
      forever #25 clk = ~clk;
   end
   pbc_regs u_pbc_regs
   (
      .clk(clk), .reset_n(reset_n), .coin_cell_por_n(coin_cell_por_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .otp(otp), .standby_req(standby_req), .turn_off(turn_off),
      .turn_on(turn_on), .buck_one_volt(volt), .buck_one_switch_mode(mode),
      .buck_one_off_mode_select(off_sel), .buck_one_enable(enable),
      .buck_one_sleep(sleep)
   );
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task rst(input logic coin);
      @(posedge clk);
      reset_n <= 1'b0;
      coin_cell_por_n <= ~coin;
      cyc(2);
      reset_n <= 1'b1;
      coin_cell_por_n <= 1'b1;
      cyc(4);
   endtask
   task ev(input logic off);
      @(posedge clk);
      turn_off <= off;
      turn_on <= ~off;
      @(posedge clk);
      turn_off <= 1'b0;
      turn_on <= 1'b0;
      cyc(5);
   endtask
   task t_reset;
      rchk(8'h1F, 8'h00);
      rchk(8'h20, {3'h0, otp.run_volt});
      rchk(8'h21, {3'h0, otp.stby_volt});
      rchk(8'h22, {3'h0, otp.sleep_volt});
      rchk(8'h23, {4'h0, otp.sw_mode});
      chk({3'h0, volt}, {3'h0, otp.run_volt});
   endtask
   // Reserved bits and unmapped places neighbouring the slice
   task t_access;
      for (int i = 0; i < 7; i++)
         wreg(8'h1E + i[7:0], 8'hFF);
      for (int i = 0; i < 7; i++)
         rchk(8'h1E + i[7:0], m[i]);
   endtask
   task t_modes;
      wreg(8'h20, 8'h11);
      wreg(8'h21, 8'h12);
      wreg(8'h22, 8'h13);
      wreg(8'h23, 8'h29);
      cyc(3);
      chk({3'h0, volt}, 8'h11);
      chk({off_sel, 3'h0, mode}, 8'h89);
      standby_req <= 1'b1;
      cyc(5);
      chk({3'h0, volt}, 8'h12);
      standby_req <= 1'b0;
      ev(1'b1);
      chk({sleep, 2'h0, volt}, 8'h93);
      ev(1'b0);
      chk({6'h00, enable, sleep}, 8'h02);
      wreg(8'h23, 8'h09);
      ev(1'b1);
      chk({7'h00, enable}, 8'h00);
      ev(1'b0);
   endtask
   // Main reset keeps scratch, reloads defaults; coin reset clears scratch
   task t_retain;
      wreg(8'h1F, 8'hA5);
      otp <= '{5'h15, 5'h0A, 5'h05, 4'h6};
      rst(1'b0);
      rchk(8'h1F, 8'hA5);
      rchk(8'h20, 8'h15);
      rchk(8'h23, 8'h06);
      rst(1'b1);
      rchk(8'h1F, 8'h00);
   endtask
   task results;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      cyc(10);
      reset_n <= 1'b1;
      coin_cell_por_n <= 1'b1;
      cyc(4);
      t_reset;
      t_access;
      t_modes;
      t_retain;
      results;
   end
   // Hang guard, far beyond the roughly 120 cycles needed
   initial
   begin
      #100000;
      miscompares++;
      results;
   end
endmodule
